// ### inc/irq_unit_pkg.sv
// Purpose: Shared constants and types for the vectored priority interrupt unit
// Assumes: Six sources, 8-bit program memory, 16-bit vectors
// Notes: Priority register encodes one of six orderings plus a reversal of the whole order
`default_nettype none
package irq_unit_pkg;

  localparam int unsigned NUM_SRC = 6;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [5:0] REQ_RESET = 6'h00;
  localparam logic [15:0] VECTOR_STRIDE = 16'h0002;
  localparam logic PIN_IDLE = 1'h1;
  localparam logic [15:0] VEC_SRC0 = 16'h0000;
  localparam logic [15:0] VEC_SRC1 = 16'h0002;
  localparam logic [15:0] VEC_SRC2 = 16'h0004;
  localparam logic [15:0] VEC_SRC3 = 16'h0006;
  localparam logic [15:0] VEC_SRC4 = 16'h0008;
  localparam logic [15:0] VEC_SRC5 = 16'h000a;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_PUSH_PCL = 7'b000_0010,
    ST_PUSH_PCH = 7'b000_0100,
    ST_PUSH_FLAGS = 7'b000_1000,
    ST_FETCH_HI = 7'b001_0000,
    ST_FETCH_LO = 7'b010_0000,
    ST_BRANCH = 7'b100_0000
  } seq_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic valid;
  } stack_push_s;

  typedef struct packed {
    logic [15:0] addr;
    logic valid;
  } vec_fetch_s;

  typedef struct packed {
    seq_state_e state;
    logic [5:0] req;
    logic [2:0] granted;
    logic [15:0] vector;
    logic comparator_in_b_d;
    logic port3_line3_d;
    logic comparator_in_a_d;
    logic global_enable;
    stack_push_s push;
    vec_fetch_s fetch;
    logic [15:0] new_pc;
    logic load_pc;
    logic busy;
  } unit_state_s;

endpackage
`default_nettype wire

// ### rtl/vectored_priority_interrupt_unit.sv
// Purpose: Six-source vectored interrupt unit for an 8-bit core
// Assumes: Pins synchronous to clk; core grants one interrupt cycle at a time
// Notes: Stack pushes and vector fetches are one-cycle strobes to the core
`timescale 1ns/1ps
`default_nettype none

module vectored_priority_interrupt_unit (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic comparator_in_b,
  input wire logic port3_line3,
  input wire logic comparator_in_a,
  input wire logic counter_timer_zero,
  input wire logic counter_timer_one,
  input wire logic [5:0] mask,
  input wire logic mask_global,
  input wire logic [7:0] priority_sel,
  input wire logic ei_pulse,
  input wire logic [15:0] pc,
  input wire logic [7:0] flags,
  input wire logic [7:0] sp,
  input wire logic [7:0] fetch_data,
  input wire logic [5:0] req_clear,
  output logic [5:0] req,
  output logic global_enable,
  output logic busy,
  output irq_unit_pkg::stack_push_s push,
  output irq_unit_pkg::vec_fetch_s fetch,
  output logic [15:0] new_pc,
  output logic load_pc
);

  irq_unit_pkg::unit_state_s st;
  irq_unit_pkg::unit_state_s next_st;
  logic [5:0] edges;
  logic [5:0] active;
  logic [2:0] winner;
  logic any_active;

  // Rank position of a source under the selected ordering
  // Sum kept four bits wide so source plus offset cannot wrap before the fold
  function automatic logic [2:0] rank_of(input logic [2:0] src, input logic [7:0] sel);
    logic [3:0] offset;
    logic [3:0] sum;
    logic [2:0] r;
    offset = 4'h0;
    unique case (sel[2:0])
      3'h1: offset = 4'h5;
      3'h2: offset = 4'h4;
      3'h3: offset = 4'h3;
      3'h4: offset = 4'h2;
      3'h5: offset = 4'h1;
      default: offset = 4'h0;
    endcase
    sum = {1'h0, src} + offset;
    if (sum >= 4'(irq_unit_pkg::NUM_SRC))
    begin
      sum = sum - 4'(irq_unit_pkg::NUM_SRC);
    end
    r = sum[2:0];
    if (sel[3])
    begin
      r = 3'h5 - r;
    end
    return r;
  endfunction

  // Edge seen against the level held one cycle earlier
  function automatic logic fell_edge(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic rose_edge(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  // Even byte of each source's vector pair; the odd byte follows it
  function automatic logic [15:0] vector_base(input logic [2:0] src);
    logic [15:0] a;
    a = irq_unit_pkg::VEC_SRC0;
    unique case (src)
      3'h0: a = irq_unit_pkg::VEC_SRC0;
      3'h1: a = irq_unit_pkg::VEC_SRC1;
      3'h2: a = irq_unit_pkg::VEC_SRC2;
      3'h3: a = irq_unit_pkg::VEC_SRC3;
      3'h4: a = irq_unit_pkg::VEC_SRC4;
      3'h5: a = irq_unit_pkg::VEC_SRC5;
      default: a = irq_unit_pkg::VEC_SRC0;
    endcase
    return a;
  endfunction

  always_comb
  begin
    edges[0] = fell_edge(st.comparator_in_b_d, comparator_in_b);
    edges[1] = fell_edge(st.port3_line3_d, port3_line3);
    edges[2] = fell_edge(st.comparator_in_a_d, comparator_in_a);
    edges[3] = rose_edge(st.comparator_in_b_d, comparator_in_b);
    edges[4] = counter_timer_zero;
    edges[5] = counter_timer_one;
    active = st.req & mask & {6{mask_global}};
    any_active = |active & st.global_enable;
    // Ranks form a permutation, so the lowest rank is never tied
    winner = 3'h0;
    for (int i = 5; i >= 0; i--)
    begin
      if (active[i] && (!active[winner] ||
          rank_of(3'(i), priority_sel) < rank_of(winner, priority_sel)))
      begin
        winner = 3'(i);
      end
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.comparator_in_b_d = comparator_in_b;
    next_st.port3_line3_d = port3_line3;
    next_st.comparator_in_a_d = comparator_in_a;
    next_st.push.valid = 1'b0;
    next_st.fetch.valid = 1'b0;
    next_st.load_pc = 1'b0;
    // Set beats clear, so an edge in the clear cycle survives
    next_st.req = (st.req & ~req_clear) | edges;
    // Enable only from idle, so a service in flight cannot be reopened
    if (ei_pulse && st.state == irq_unit_pkg::ST_IDLE)
    begin
      next_st.global_enable = 1'b1;
    end
    unique case (st.state)
      irq_unit_pkg::ST_IDLE:
      begin
        if (any_active)
        begin
          next_st.global_enable = 1'b0;
          next_st.granted = winner;
          // A fresh edge on the granted source keeps its request
          next_st.req[winner] = edges[winner];
          next_st.push = '{addr: 8'(sp - 8'h01), data: pc[7:0], valid: 1'b1};
          next_st.busy = 1'b1;
          next_st.state = irq_unit_pkg::ST_PUSH_PCH;
        end
      end
      irq_unit_pkg::ST_PUSH_PCH:
      begin
        next_st.push = '{addr: 8'(sp - 8'h02), data: pc[15:8], valid: 1'b1};
        next_st.state = irq_unit_pkg::ST_PUSH_FLAGS;
      end
      irq_unit_pkg::ST_PUSH_FLAGS:
      begin
        next_st.push = '{addr: 8'(sp - 8'h03), data: flags, valid: 1'b1};
        next_st.fetch = '{addr: vector_base(st.granted), valid: 1'b1};
        next_st.state = irq_unit_pkg::ST_FETCH_HI;
      end
      // Byte answered in the strobe cycle; high byte from the even address
      irq_unit_pkg::ST_FETCH_HI:
      begin
        next_st.vector[15:8] = fetch_data;
        next_st.fetch = '{addr: 16'(st.fetch.addr + 16'h0001), valid: 1'b1};
        next_st.state = irq_unit_pkg::ST_FETCH_LO;
      end
      irq_unit_pkg::ST_FETCH_LO:
      begin
        next_st.new_pc = {st.vector[15:8], fetch_data};
        next_st.load_pc = 1'b1;
        next_st.state = irq_unit_pkg::ST_BRANCH;
      end
      irq_unit_pkg::ST_BRANCH:
      begin
        next_st.busy = 1'b0;
        next_st.state = irq_unit_pkg::ST_IDLE;
      end
      default:
      begin
        next_st.state = irq_unit_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.state <= irq_unit_pkg::ST_IDLE;
      st.req <= irq_unit_pkg::REQ_RESET;
      // History idles high, so a pin held high at release raises no request
      st.comparator_in_b_d <= irq_unit_pkg::PIN_IDLE;
      st.port3_line3_d <= irq_unit_pkg::PIN_IDLE;
      st.comparator_in_a_d <= irq_unit_pkg::PIN_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign req = st.req;
  assign global_enable = st.global_enable;
  assign busy = st.busy;
  assign push = st.push;
  assign fetch = st.fetch;
  assign new_pc = st.new_pc;
  assign load_pc = st.load_pc;

endmodule

`default_nettype wire

// ### test/irq_unit_asserts.sv
// Purpose: Port checker for the interrupt unit
// Assumes: Sp, pc and flags held steady through a service
// Notes: Bound to the unit top
`timescale 1ns/1ps
`default_nettype none
module irq_unit_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic comparator_in_b,
  input wire logic port3_line3,
  input wire logic mask_global,
  input wire logic [5:0] mask,
  input wire logic [7:0] sp,
  input wire logic [15:0] pc,
  input wire logic [7:0] flags,
  input wire logic [5:0] req,
  input wire logic global_enable,
  input wire logic busy,
  input wire irq_unit_pkg::stack_push_s push,
  input wire irq_unit_pkg::vec_fetch_s fetch,
  input wire logic load_pc
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_grant_gate: assert property ($rose(busy) |-> !global_enable && $past(mask_global)
    && |($past(req) & $past(mask))) else $error("grant");
  a_push_order: assert property ($rose(busy) |-> push.valid && push.addr == sp - 8'h01
    ##1 push.valid && push.addr == sp - 8'h02 ##1 push.valid && push.addr == sp - 8'h03)
    else $error("push");
  a_fetch_pair: assert property ($rose(busy) |-> ##2 fetch.valid && !fetch.addr[0]
    && fetch.addr < 16'h000c ##1 fetch.valid && fetch.addr[0]) else $error("fetch");
  a_load_delay: assert property ($rose(busy) |-> !load_pc [*4] ##1 load_pc)
    else $error("load");
  a_push_data: assert property ($rose(busy) |-> push.data == pc[7:0]
    ##1 push.data == pc[15:8] ##1 push.data == flags) else $error("data");
  a_fall_zero: assert property ($fell(comparator_in_b) |=> req[0])
    else $error("src0");
  a_rise_three: assert property ($rose(comparator_in_b) |=> req[3])
    else $error("src3");
  a_fall_one: assert property ($fell(port3_line3) |=> req[1]) else $error("src1");
  a_reset_clear: assert property ($rose(reset_n) |-> req == 6'h00 && !global_enable)
    else $error("reset");
endmodule
bind vectored_priority_interrupt_unit irq_unit_asserts chk (.clk, .reset_n, .comparator_in_b,
  .port3_line3, .mask_global, .mask, .sp, .pc, .flags, .req, .global_enable, .busy,
  .push, .fetch, .load_pc);
`default_nettype wire

// ### test/core_mem_model.sv
// Purpose: Program memory side of the core
// Assumes: Byte answered within the strobe cycle, latched by the unit at the next edge
// Notes: Idle bus shows the inverted last byte
`timescale 1ns/1ps
`default_nettype none
module core_mem_model (
  input wire logic clk,
  input wire irq_unit_pkg::vec_fetch_s fetch,
  output logic [7:0] fetch_data
);
  logic [7:0] last_byte = 8'h00;
  always_comb
    fetch_data = fetch.valid ? {~fetch.addr[3:0], fetch.addr[3:0]} : ~last_byte;
  always @(posedge clk)
    if (fetch.valid) last_byte <= fetch_data;
endmodule
`default_nettype wire

// ### test/tb_vectored_priority_interrupt_unit.sv
// Purpose: Self-checking bench for the interrupt unit
// Assumes: Rotate and reverse priority encoding
// Notes: Sources fire only while globally masked
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_priority_interrupt_unit;
  logic clk = 0, reset_n = 0, comparator_in_b = 1, port3_line3 = 1, comparator_in_a = 1;
  logic counter_timer_zero = 0, counter_timer_one = 0, mask_global = 0, ei_pulse = 0, got;
  logic [5:0] mask = 0, req_clear = 0, req, m = 0;
  logic [7:0] priority_sel = 0, flags = 0, sp = 0, fetch_data;
  logic [15:0] pc = 0, new_pc;
  logic [3:0] v;
  logic global_enable, busy, load_pc;
  irq_unit_pkg::stack_push_s push;
  irq_unit_pkg::vec_fetch_s fetch;
  int num_errors = 0, n_checks = 0, w, r;
  initial forever #2.5 clk = ~clk;
  vectored_priority_interrupt_unit dut (.clk, .reset_n, .comparator_in_b, .port3_line3,
    .comparator_in_a, .counter_timer_zero, .counter_timer_one, .mask, .mask_global,
    .priority_sel, .ei_pulse, .pc, .flags, .sp, .fetch_data, .req_clear, .req,
    .global_enable, .busy, .push, .fetch, .new_pc, .load_pc);
  core_mem_model mem (.clk, .fetch, .fetch_data);
  task check(logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic int at(int i);
    return priority_sel[3] ? (r + 11 - i) % 6 : (r + i) % 6;
  endfunction
  task automatic fire(int s);
    @(posedge clk);
    if (s == 0 || s == 3) m[comparator_in_b ? 0 : 3] = 1;
    else m[s] = 1;
    case (s)
      0, 3: comparator_in_b <= ~comparator_in_b;
      1: port3_line3 <= 0;
      2: comparator_in_a <= 0;
      4: counter_timer_zero <= 1;
      default: counter_timer_one <= 1;
    endcase
    @(posedge clk);
    {port3_line3, comparator_in_a, counter_timer_zero, counter_timer_one} <= 4'hc;
  endtask
  initial
  begin
    r = $urandom(32);
    repeat (2) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    #1 check(req, 0);
    repeat (40)
    begin
      @(posedge clk);
      mask_global <= 0;
      for (int s = 0; s < 6; s++) if ($urandom % 2) fire(s);
      repeat (2) @(posedge clk);
      #1 check(req, m);
      @(posedge clk);
      {mask, mask_global, priority_sel, sp} <= 23'($urandom);
      {pc, flags} <= 24'($urandom);
      ei_pulse <= 1;
      @(posedge clk);
      ei_pulse <= 0;
      w = -1;
      r = priority_sel[2:0] > 5 ? 0 : priority_sel[2:0];
      for (int i = 5; i >= 0; i--)
        if (mask_global && m[at(i)] && mask[at(i)]) w = at(i);
      got = 0;
      for (int k = 0; k < 12 && got !== 1; k++)
      begin
        @(posedge clk);
        #1 got = load_pc;
      end
      check(got, w >= 0);
      if (got !== 1 && w >= 0) stop_test;
      if (got === 1 && w >= 0)
      begin
        v = 4'(2 * w);
        check(new_pc, {~v, v, ~(v | 4'h1), v | 4'h1});
        m[w] = 0;
      end
      repeat (2) @(posedge clk);
      #1 check(busy, 0);
      check(req, m);
      @(posedge clk);
      req_clear <= 6'($urandom);
      @(posedge clk);
      m = m & ~req_clear;
      req_clear <= 0;
    end
    stop_test;
  end
endmodule
`default_nettype wire
